/* verilog/tid_decode_front_end.sv */
// in-order fetch, byte queue and three-slot decode selection front end
// Overview of operation
// - fetch reads 16-byte code windows aligned on 16-byte boundaries
// - fetched bytes append to a 24-byte queue feeding decode selection
// - each instruction is classed as hardware-decoded or ROM-sequenced
// - up to three hardware-decoded instructions selected per cycle, in order
// - at most one ROM-sequenced instruction selected per cycle
// - a cycle never mixes hardware-decoded and ROM-sequenced instructions
// - floating-point ops with integer memory operand go ROM path, two operations
// - shift right and address computation hardware; double left shift ROM
// - partial register writes merge with the untouched rest of the register
// - a reader depends on the latest writer of any part of that register
// - no-op with up to two repeat prefixes uses one slot, no overhead
// - redundant prefixes dropped; no-ops use no resources, only advance the pointer
// - short sign-extended 8-bit immediate form decodes without penalty
// - zero-count double shifts still take the ROM sequence and resources
// - three prefixed no-ops decode in one cycle, up to nine bytes
`timescale 1ns/10ps
`default_nettype none
module tid_decode_front_end
   import tid_pkg::*;
#(
   parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic rst,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   input wire logic fetch_valid,
   input wire logic [8*WINDOW_BYTES-1:0] fetch_data,
   input wire logic branch_taken,
   input wire logic [31:0] branch_target,
   input wire logic sched_ready,
   output logic [SLOTS-1:0] slot_valid,
   output logic [SLOTS-1:0] slot_rom,
   output logic [4*SLOTS-1:0] slot_len,
   output logic [2*SLOTS-1:0] slot_ops,
   output logic [4*SLOTS-1:0] slot_tag,
   output logic [SLOTS-1:0] slot_dep_valid,
   output logic [4*SLOTS-1:0] slot_dep_tag,
   output logic [SLOTS-1:0] slot_partial,
   output logic [31:0] instruction_pointer,
   input wire logic wb_valid,
   input wire logic [2:0] wb_reg,
   input wire logic [1:0] wb_size,
   input wire logic [31:0] wb_data,
   input wire logic [2:0] rf_sel,
   output logic [31:0] rf_data
);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [1:0] sz);
      case (sz)
         SZ_BYTE: merge = {old[31:8], d[7:0]};
         SZ_WORD: merge = {old[31:16], d[15:0]};
         default: merge = d;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   tid_fetch_state_t fs, next_fs;
   logic [7:0] q [QUEUE_BYTES];
   logic [7:0] next_q [QUEUE_BYTES];
   logic [4:0] qcount, next_qcount;
   logic [31:0] next_window;
   logic [3:0] skip;
   logic [3:0] next_tag, next_next_tag;
   logic [3:0] lw_tag [REGS];
   logic lw_valid [REGS];
   logic [3:0] next_lw_tag [REGS];
   logic next_lw_valid [REGS];
   logic [31:0] rf [REGS];

   ////////////////////////////////////////////////////////////////////////////////
   // slot classification and selection

   logic [5:0] off [SLOTS];
   logic [8*CLS_BYTES-1:0] win [SLOTS];
   logic [3:0] c_len [SLOTS];
   logic c_rom [SLOTS];
   logic [1:0] c_ops [SLOTS];
   logic c_reg_en [SLOTS];
   logic [2:0] c_reg [SLOTS];
   logic c_partial [SLOTS];
   logic fit [SLOTS];
   logic [SLOTS-1:0] sel;
   logic go, append;
   logic [5:0] consumed;

   function automatic logic [8*CLS_BYTES-1:0] win_at(input logic [5:0] o);
      logic [8*CLS_BYTES-1:0] w;
      w = '0;
      for (int i = 0; i < CLS_BYTES; i++) begin
         if (int'(o) + i < QUEUE_BYTES) begin
            w[8*i +: 8] = q[int'(o) + i];
         end
      end
      win_at = w;
   endfunction

   assign off[0] = 6'h00;
   assign off[1] = {2'b00, c_len[0]};
   assign off[2] = off[1] + {2'b00, c_len[1]};

   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         assign win[g] = win_at(off[g]);
         // only a fully queued instruction is decoded
         assign fit[g] = (off[g] + {2'b00, c_len[g]}) <= {1'b0, qcount};
         tid_classify u_cls (
            .win(win[g]),
            .len(c_len[g]),
            .rom(c_rom[g]),
            .internal_operations(c_ops[g]),
            .reg_en(c_reg_en[g]),
            .reg_num(c_reg[g]),
            .partial(c_partial[g])
         );
      end
   endgenerate

   assign go = sched_ready && !branch_taken;
   assign sel[0] = go && fit[0];
   // a ROM-sequenced head issues alone; a later one waits for the next cycle
   assign sel[1] = sel[0] && !c_rom[0] && !c_rom[1] && fit[1];
   assign sel[2] = sel[1] && !c_rom[2] && fit[2];
   assign consumed = (sel[2] ? off[2] + {2'b00, c_len[2]} :
                      sel[1] ? off[1] + {2'b00, c_len[1]} :
                      sel[0] ? {2'b00, c_len[0]} : 6'h00);
   assign append = fetch_valid && (fs == TID_FS_WAIT) && !branch_taken;

   ////////////////////////////////////////////////////////////////////////////////
   // queue shift and append

   always_comb begin
      int keep;
      int j;
      keep = int'(qcount) - int'(consumed);
      j = 0;
      next_qcount = 5'h00;
      for (int i = 0; i < QUEUE_BYTES; i++) begin
         next_q[i] = 8'h00;
         if (i < keep) begin
            next_q[i] = q[i + int'(consumed)];
         end else if (append) begin
            j = i - keep + int'(skip);
            if (j < WINDOW_BYTES) begin
               next_q[i] = fetch_data[8*j +: 8];
            end
         end
      end
      if (!branch_taken) begin
         next_qcount = qcount - consumed[4:0];
         if (append) begin
            next_qcount = next_qcount + 5'(WINDOW_STEP - {2'b00, skip});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fetch sequencing

   always_comb begin
      next_fs = fs;
      case (fs)
         TID_FS_IDLE: begin
            // low water keeps a whole window of room free
            if (!branch_taken && qcount <= FETCH_LOW_WATER) begin
               next_fs = TID_FS_WAIT;
            end
         end
         TID_FS_WAIT: begin
            if (branch_taken) begin
               // the window in flight belongs to the old path
               next_fs = fetch_valid ? TID_FS_IDLE : TID_FS_STALE;
            end else if (fetch_valid) begin
               next_fs = TID_FS_IDLE;
            end
         end
         TID_FS_STALE: begin
            if (fetch_valid) begin
               next_fs = TID_FS_IDLE;
            end
         end
         default: next_fs = TID_FS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fs <= TID_FS_IDLE;
         fetch_req <= 1'b0;
         fetch_addr <= {RESET_VECTOR[31:4], 4'h0};
         next_window <= {RESET_VECTOR[31:4], 4'h0};
         skip <= RESET_VECTOR[3:0];
         instruction_pointer <= RESET_VECTOR;
      end else begin
         fs <= next_fs;
         fetch_req <= (fs == TID_FS_IDLE) && (next_fs == TID_FS_WAIT);
         if (fs == TID_FS_IDLE && next_fs == TID_FS_WAIT) begin
            fetch_addr <= next_window;
         end
         if (branch_taken) begin
            next_window <= {branch_target[31:4], 4'h0};
            skip <= branch_target[3:0];
            instruction_pointer <= branch_target;
         end else begin
            if (append) begin
               next_window <= next_window + WINDOW_ADDR_STEP;
               skip <= 4'h0;
            end
            // no-ops only move the pointer
            instruction_pointer <= instruction_pointer + {26'h0, consumed};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         qcount <= 5'h00;
         for (int i = 0; i < QUEUE_BYTES; i++) begin
            q[i] <= 8'h00;
         end
      end else begin
         qcount <= next_qcount;
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // dependency tagging

   logic [3:0] s_tag [SLOTS];
   logic s_dep_v [SLOTS];
   logic [3:0] s_dep_t [SLOTS];

   always_comb begin
      next_next_tag = next_tag;
      for (int r = 0; r < REGS; r++) begin
         next_lw_tag[r] = lw_tag[r];
         next_lw_valid[r] = lw_valid[r];
      end
      for (int k = 0; k < SLOTS; k++) begin
         // whole-register granularity: any part read waits on any part written
         s_dep_v[k] = c_reg_en[k] && next_lw_valid[c_reg[k]];
         s_dep_t[k] = next_lw_tag[c_reg[k]];
         s_tag[k] = next_next_tag;
         if (sel[k] && c_ops[k] != OPS_NONE) begin
            next_next_tag = next_next_tag + 4'h1;
            if (c_reg_en[k]) begin
               next_lw_valid[c_reg[k]] = 1'b1;
               next_lw_tag[c_reg[k]] = s_tag[k];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         next_tag <= 4'h0;
         for (int r = 0; r < REGS; r++) begin
            lw_tag[r] <= 4'h0;
            lw_valid[r] <= 1'b0;
         end
      end else begin
         next_tag <= next_next_tag;
         lw_tag <= next_lw_tag;
         lw_valid <= next_lw_valid;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_valid <= '0;
         slot_rom <= '0;
         slot_len <= '0;
         slot_ops <= '0;
         slot_tag <= '0;
         slot_dep_valid <= '0;
         slot_dep_tag <= '0;
         slot_partial <= '0;
      end else begin
         slot_valid <= sel;
         for (int k = 0; k < SLOTS; k++) begin
            slot_rom[k] <= sel[k] && c_rom[k];
            slot_len[4*k +: 4] <= sel[k] ? c_len[k] : 4'h0;
            slot_ops[2*k +: 2] <= sel[k] ? c_ops[k] : OPS_NONE;
            slot_tag[4*k +: 4] <= s_tag[k];
            slot_dep_valid[k] <= sel[k] && s_dep_v[k];
            slot_dep_tag[4*k +: 4] <= s_dep_t[k];
            slot_partial[k] <= sel[k] && c_partial[k];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // architectural registers with partial-write merge

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rf_data <= 32'h0000_0000;
         for (int r = 0; r < REGS; r++) begin
            rf[r] <= 32'h0000_0000;
         end
      end else begin
         if (wb_valid) begin
            rf[wb_reg] <= merge(rf[wb_reg], wb_data, wb_size);
         end
         rf_data <= rf[rf_sel];
      end
   end
endmodule
`default_nettype wire

/* inc/tid_pkg.sv */
// constants, opcodes and types shared by the decode front end and its classifier
package tid_pkg;
   localparam int QUEUE_BYTES = 24;
   localparam int WINDOW_BYTES = 16;
   localparam int SLOTS = 3;
   localparam int CLS_BYTES = 6;
   localparam int REGS = 8;
   localparam logic [4:0] FETCH_LOW_WATER = 5'h08;
   localparam logic [5:0] WINDOW_STEP = 6'h10;
   localparam logic [31:0] WINDOW_ADDR_STEP = 32'h0000_0010;

   localparam logic [7:0] OP_NOP = 8'h90;
   localparam logic [7:0] OP_REP = 8'hF3;
   localparam logic [7:0] OP_ALU_IMM8S = 8'h83;
   localparam logic [7:0] OP_ALU_IMM32 = 8'h81;
   localparam logic [7:0] OP_ALU_IMM8B = 8'h80;
   localparam logic [7:0] OP_SHIFT_IMM = 8'hC1;
   localparam logic [7:0] OP_LEA = 8'h8D;
   localparam logic [7:0] OP_ESC = 8'h0F;
   localparam logic [7:0] OP_DSHL_IMM = 8'hA4;
   localparam logic [7:0] OP_DSHL_CL = 8'hA5;
   localparam logic [7:0] OP_DSHR_IMM = 8'hAC;
   localparam logic [7:0] OP_DSHR_CL = 8'hAD;
   localparam logic [7:0] OP_FP_INT32 = 8'hDA;
   localparam logic [7:0] OP_FP_INT16 = 8'hDE;
   localparam logic [7:0] OP_MOV_TO8 = 8'h88;
   localparam logic [7:0] OP_MOV_TO = 8'h89;
   localparam logic [7:0] OP_MOV_FROM8 = 8'h8A;
   localparam logic [7:0] OP_MOV_FROM = 8'h8B;

   localparam logic [1:0] OPS_NONE = 2'h0;
   localparam logic [1:0] OPS_HW = 2'h1;
   localparam logic [1:0] OPS_ROM_FPINT = 2'h2;
   localparam logic [1:0] OPS_ROM_DSHIFT = 2'h3;

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;

   typedef enum logic [2:0] {
      TID_FS_IDLE = 3'b001,
      TID_FS_WAIT = 3'b010,
      TID_FS_STALE = 3'b100
   } tid_fetch_state_t;
endpackage

/* verilog/tid_classify.sv */
// length and decode-kind classifier for one instruction at the head of a byte window
`timescale 1ns/10ps
`default_nettype none
module tid_classify
   import tid_pkg::*;
(
   input wire logic [8*CLS_BYTES-1:0] win,
   output logic [3:0] len,
   output logic rom,
   output logic [1:0] internal_operations,
   output logic reg_en,
   output logic [2:0] reg_num,
   output logic partial
);

   function automatic logic [7:0] byte_at(input logic [8*CLS_BYTES-1:0] w, input logic [2:0] i);
      byte_at = w[8*i +: 8];
   endfunction

   // bytes taken by modrm, sib and displacement
   function automatic logic [3:0] mlen(input logic [7:0] m, input logic [7:0] s);
      logic [3:0] n;
      n = 4'h1;
      case (m[7:6])
         2'b00: begin
            if (m[2:0] == 3'h5) begin
               n = 4'h5;
            end else if (m[2:0] == 3'h4) begin
               n = (s[2:0] == 3'h5) ? 4'h6 : 4'h2;
            end
         end
         2'b01: n = (m[2:0] == 3'h4) ? 4'h3 : 4'h2;
         2'b10: n = (m[2:0] == 3'h4) ? 4'h6 : 4'h5;
         default: n = 4'h1;
      endcase
      mlen = n;
   endfunction

   logic [2:0] pre;
   logic [7:0] op, m1, m2;
   logic [3:0] base, ml1, ml2;
   logic reg_form;

   // up to two redundant repeat prefixes are swallowed here
   assign pre = (byte_at(win, 3'h0) != OP_REP) ? 3'h0 : (byte_at(win, 3'h1) != OP_REP) ? 3'h1 : 3'h2;
   assign op = byte_at(win, pre);
   assign m1 = byte_at(win, pre + 3'h1);
   assign m2 = byte_at(win, pre + 3'h2);
   assign base = {1'b0, pre} + 4'h1;
   assign ml1 = mlen(m1, m2);
   assign ml2 = mlen(m2, byte_at(win, pre + 3'h3));
   assign reg_form = (m1[7:6] == 2'b11);

   always_comb begin
      len = base;
      rom = 1'b0;
      internal_operations = OPS_HW;
      reg_en = 1'b0;
      reg_num = m1[2:0];
      partial = 1'b0;
      case (op)
         OP_NOP: internal_operations = OPS_NONE;
         OP_ALU_IMM8S: begin
            len = base + ml1 + 4'h1;
            reg_en = reg_form;
         end
         OP_ALU_IMM32: begin
            len = base + ml1 + 4'h4;
            reg_en = reg_form;
         end
         OP_ALU_IMM8B: begin
            len = base + ml1 + 4'h1;
            reg_en = reg_form;
            partial = 1'b1;
         end
         OP_SHIFT_IMM: begin
            len = base + ml1 + 4'h1;
            reg_en = reg_form;
         end
         OP_LEA: begin
            len = base + ml1;
            reg_en = 1'b1;
            reg_num = m1[5:3];
         end
         OP_MOV_TO8, OP_MOV_TO: begin
            len = base + ml1;
            reg_en = reg_form;
            partial = (op == OP_MOV_TO8);
         end
         OP_MOV_FROM8, OP_MOV_FROM: begin
            len = base + ml1;
            reg_en = 1'b1;
            reg_num = m1[5:3];
            partial = (op == OP_MOV_FROM8);
         end
         OP_FP_INT32, OP_FP_INT16: begin
            len = base + ml1;
            rom = !reg_form;
            internal_operations = reg_form ? OPS_HW : OPS_ROM_FPINT;
         end
         OP_ESC: begin
            len = base + 4'h1;
            if (m1 == OP_DSHL_IMM || m1 == OP_DSHL_CL || m1 == OP_DSHR_IMM || m1 == OP_DSHR_CL) begin
               // a zero count still goes through the sequence
               len = base + 4'h1 + ml2 + ((m1[0] == 1'b0) ? 4'h1 : 4'h0);
               rom = 1'b1;
               internal_operations = OPS_ROM_DSHIFT;
               reg_en = (m2[7:6] == 2'b11);
               reg_num = m2[2:0];
            end
         end
         default: len = base;
      endcase
   end
endmodule
`default_nettype wire

/* tb/tid_decode_front_end_sva.sv */
// port-level assertions for the decode front end
`timescale 1ns/10ps
`default_nettype none
module tid_checker
   import tid_pkg::*;
#(
   parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic branch_taken,
   input wire logic [31:0] branch_target,
   input wire logic sched_ready,
   input wire logic [SLOTS-1:0] slot_valid,
   input wire logic [SLOTS-1:0] slot_rom,
   input wire logic [4*SLOTS-1:0] slot_len,
   input wire logic [2*SLOTS-1:0] slot_ops,
   input wire logic [31:0] instruction_pointer
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // remembers the redirect until the refetch goes out
   logic pend;
   logic [31:0] tgt;
   logic [4:0] wait_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend <= 1'b0;
         tgt <= 32'h0;
         wait_cnt <= 5'h0;
      end else if (branch_taken) begin
         pend <= 1'b1;
         tgt <= branch_target;
         wait_cnt <= 5'h0;
      end else if (fetch_req) begin
         pend <= 1'b0;
      end else if (pend) begin
         wait_cnt <= wait_cnt + 5'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_quiet;
      !branch_taken ##1 (slot_valid == 3'h0);
   endsequence
   sequence s_single;
      !branch_taken ##1 (slot_valid == 3'h1);
   endsequence
   a_fetch_aligned: assert property (fetch_req |-> fetch_addr[3:0] == 4'h0)
      else $error("fetch window not aligned");
   a_refetch_target: assert property (pend && fetch_req |-> fetch_addr == {tgt[31:4], 4'h0})
      else $error("refetch not at target window");
   a_refetch_bound: assert property (pend |-> wait_cnt < 5'd20)
      else $error("refetch too late");
   a_branch_flush: assert property (branch_taken |=> slot_valid == 3'h0 && instruction_pointer == $past(branch_target))
      else $error("branch did not flush");
   a_slots_contig: assert property (slot_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
      else $error("slots not in order");
   a_rom_alone: assert property (slot_valid[0] && slot_rom[0] |-> slot_valid[2:1] == 2'h0)
      else $error("rom instruction not alone");
   a_rom_slot_zero: assert property ((slot_valid[2:1] & slot_rom[2:1]) == 2'h0)
      else $error("rom instruction in later slot");
   a_rom_ops: assert property (slot_valid[0] && slot_rom[0] |-> slot_ops[1:0] >= OPS_ROM_FPINT)
      else $error("rom instruction with too few operations");
   a_stall_idle: assert property (!sched_ready |=> slot_valid == 3'h0)
      else $error("selection while stalled");
   a_ip_hold: assert property (s_quiet |-> $stable(instruction_pointer))
      else $error("pointer moved with nothing issued");
   a_ip_step: assert property (s_single |-> instruction_pointer == $past(instruction_pointer) + slot_len[3:0])
      else $error("pointer step wrong");
endmodule
bind tid_decode_front_end tid_checker #(.RESET_VECTOR(RESET_VECTOR)) tid_checker_i (.*);
`default_nettype wire

/* tb/tid_icache_model.sv */
// instruction cache model answering window requests in order with a varying delay
`timescale 1ns/10ps
`default_nettype none
module tid_icache_model
   import tid_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] lat,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_valid,
   output logic [8*WINDOW_BYTES-1:0] fetch_data
);
   logic [7:0] mem [0:127];
   logic [31:0] pend_q [$];
   logic [31:0] a;
   int cnt;
   // requests queue up, so a response dropped after a flush still arrives
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q.delete();
         cnt <= 0;
         fetch_valid <= 1'b0;
         fetch_data <= '0;
      end else begin
         fetch_valid <= 1'b0;
         // idle bus toggles so stale bytes never look like a window
         fetch_data <= ~fetch_data;
         if (fetch_req) pend_q.push_back(fetch_addr);
         if (cnt != 0) begin
            cnt <= cnt - 1;
         end else if (pend_q.size() != 0) begin
            a = pend_q.pop_front();
            for (int i = 0; i < 16; i++) fetch_data[8*i +: 8] <= mem[(a + i) & 127];
            fetch_valid <= 1'b1;
            cnt <= int'(lat);
         end
      end
   end
endmodule
`default_nettype wire

/* tb/tb_tid_decode_front_end.sv */
// self-checking bench for the decode front end
`timescale 1ns/10ps
`default_nettype none
module tb_tid_decode_front_end;
   import tid_pkg::*;
   logic clk, rst, fetch_req, fetch_valid, branch_taken, sched_ready, wb_valid;
   logic [31:0] fetch_addr, branch_target, instruction_pointer, wb_data, rf_data;
   logic [127:0] fetch_data;
   logic [2:0] slot_valid, slot_rom, slot_dep_valid, slot_partial, wb_reg, rf_sel;
   logic [11:0] slot_len, slot_tag, slot_dep_tag;
   logic [5:0] slot_ops;
   logic [1:0] wb_size, lat;
   logic [3:0] prev_tag;
   logic have_prev, br_pend, saw_three;
   logic [31:0] exp_rf [0:7];
   int n_errors, comparisons, seed, cycles, exp_ptr, pos;
   int bounds[$];
   // nop, rep nop, rep rep nop, short imm add, long imm add, fp int mem,
   // double shift 1, double shift 0, shift right, address computation, move
   localparam logic [47:0] TPL [11] = '{48'h90, 48'hF390, 48'hF3F390, 48'h83C3FB,
      48'h81C3FFFFFFFF, 48'hDA00, 48'h0FA4C001, 48'h0FA4C000, 48'hC1E81F, 48'h8D0440, 48'h88D8};
   localparam int TLEN [11] = '{1, 2, 3, 3, 6, 2, 4, 4, 3, 3, 2};
   tid_decode_front_end tid_decode_front_end_i (.*);
   tid_icache_model tid_icache_model_i (.clk(clk), .rst(rst), .lat(lat), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [7:0] mb(int ad);
      return tid_icache_model_i.mem[ad & 127];
   endfunction
   // returns {rom, ops, len} for the instruction at ad
   function automatic logic [6:0] expect_inst(int ad);
      int p = 0;
      while (p < 2 && mb(ad + p) == OP_REP) p++;
      case (mb(ad + p))
         OP_NOP: return {1'b0, OPS_NONE, 4'(p + 1)};
         OP_ALU_IMM8S, OP_SHIFT_IMM, OP_LEA: return {1'b0, OPS_HW, 4'h3};
         OP_ALU_IMM32: return {1'b0, OPS_HW, 4'h6};
         OP_FP_INT32: return {1'b1, OPS_ROM_FPINT, 4'h2};
         OP_ESC: return {1'b1, OPS_ROM_DSHIFT, 4'h4};
         default: return {1'b0, OPS_HW, 4'h2};
      endcase
   endfunction
   function automatic logic [31:0] merge(logic [31:0] o, logic [1:0] sz, logic [31:0] d);
      if (sz == SZ_BYTE) return {o[31:8], d[7:0]};
      if (sz == SZ_WORD) return {o[31:16], d[15:0]};
      return d;
   endfunction
   task automatic put(int t);
      for (int i = 0; i < TLEN[t]; i++) tid_icache_model_i.mem[pos + i] = TPL[t][8*(TLEN[t]-1-i) +: 8];
      bounds.push_back(pos);
      pos += TLEN[t];
   endtask
   task automatic check_slots();
      logic [6:0] e;
      if (br_pend) begin
         check_val(32'(slot_valid), 32'h0);
         exp_ptr = int'(branch_target);
         br_pend = 1'b0;
      end else begin
         if (slot_valid == 3'h7 && slot_ops == 6'h0) saw_three = 1'b1;
         for (int s = 0; s < 3; s++) begin
            if (slot_valid[s] === 1'b1) begin
               e = expect_inst(exp_ptr);
               check_val(32'({slot_rom[s], slot_ops[2*s +: 2], slot_len[4*s +: 4]}), 32'(e));
               check_val(32'(slot_partial[s]), 32'(mb(exp_ptr) == OP_MOV_TO8));
               if (mb(exp_ptr) inside {OP_ALU_IMM8S, OP_ALU_IMM32}) begin
                  if (have_prev) check_val(32'({slot_dep_valid[s], slot_dep_tag[4*s +: 4]}), 32'({1'b1, prev_tag}));
                  have_prev = 1'b1;
                  prev_tag = slot_tag[4*s +: 4];
               end
               exp_ptr += int'(e[3:0]);
            end
         end
      end
      check_val(instruction_pointer, 32'(exp_ptr));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      {rst, branch_taken, sched_ready, wb_valid, have_prev, br_pend, saw_three} = 7'h40;
      {branch_target, wb_data, wb_reg, wb_size, rf_sel, lat} = '0;
      seed = 32'h1cb1;
      pos = 0;
      // three padded nops first, then a nop, a short imm add and a zero-count double shift
      repeat (3) put(2);
      put(0);
      put(3);
      put(7);
      while (pos < 122) put($unsigned($random(seed)) % 11);
      while (pos < 128) put(0);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check_val(32'({fetch_req, slot_valid, rf_data}), 32'h0);
      check_val(instruction_pointer, 32'h0);
      rst = 1'b0;
      sched_ready = 1'b1;
      exp_ptr = 0;
      repeat (1500) begin
         @(negedge clk);
         check_slots();
         branch_taken = 1'b0;
         sched_ready = cycles < 40 || ($random(seed) & 3) != 0;
         lat = 2'($random(seed));
         if (cycles > 40 && ($random(seed) & 63) == 0) begin
            branch_taken = 1'b1;
            branch_target = 32'(bounds[$unsigned($random(seed)) % bounds.size()]);
            br_pend = 1'b1;
         end
      end
      check_val(32'(saw_three), 32'h1);
      for (int k = 0; k < 12; k++) begin
         @(negedge clk);
         wb_valid = 1'b1;
         wb_reg = 3'(k / 4 * 3);
         wb_size = (k % 4 == 0) ? 2'h2 : (k % 4 == 3) ? 2'($random(seed)) : 2'(k % 4 - 1);
         wb_data = $random(seed);
         rf_sel = wb_reg;
         exp_rf[wb_reg] = merge(exp_rf[wb_reg], wb_size, wb_data);
         @(negedge clk);
         wb_valid = 1'b0;
         @(negedge clk);
         check_val(rf_data, exp_rf[rf_sel]);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
